//--- rtl/rxfp_regs.sv
// Receive frame policy registers with AHB-Lite slave
//
// Behaviour
// - Writing one to a clear bit turns that channel's unicast enable off.
// - Maximum frame length is sixteen bits, resetting to 1518.
// - Frames with byte count above the maximum are long.
// - Long frames without errors are oversized.
// - Long frames with CRC, code or alignment error are jabber.
// - Skip value is copied into each first descriptor's offset field.
// - Data lands after the skipped leading bytes; zero means byte zero.
// - One skip setting serves every channel.
// - An eight-bit free-buffer threshold governs low-priority filtering.
// - Each channel has an eight-bit flow threshold, used only when enabled.
// - Low-priority threshold compares against the channel free buffer count.
// - Flow threshold compares against that channel's free count when enabled.
// - Writing one to a set bit enables unicast; state is readable.
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module rxfp_regs #(
	parameter int CHANNELS = 8
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Receive path
	input wire rxfp_pkg::rxfp_frame_end_t frame_end,
	input wire logic sop_req,
	input wire logic [CHANNELS-1:0] frame_buffers_used,
	// Results
	output rxfp_pkg::rxfp_class_t frame_class,
	output logic frame_class_valid,
	output rxfp_pkg::rxfp_sop_t sop_fields,
	output logic sop_valid,
	output logic [CHANNELS-1:0] channel_unicast_accept,
	output logic [CHANNELS-1:0] low_filter,
	output logic [CHANNELS-1:0] flow_issue
);
	import rxfp_pkg::*;

	logic [CHANNELS-1:0] uc_reg;
	logic [15:0] max_frame_bytes_reg;
	logic [15:0] lead_skip_bytes_reg;
	logic [7:0] low_priority_cutoff_reg;
	logic flow_en_reg;
	logic [CHANNELS*8-1:0] flow_level_reg;
	logic [CHANNELS*16-1:0] free_count_reg;

	// Address phase capture
	logic wr_pend_reg;
	logic [11:0] addr_reg;
	logic rd_pend;
	logic [31:0] rdata_next;
	logic addr_ph;

	// Data phase write strobes, one per register
	logic wr_uc_set;
	logic wr_uc_clr;
	logic wr_maxlen;
	logic wr_skip;
	logic wr_lowth;
	logic wr_flowen;
	logic [CHANNELS-1:0] uc_next;

	// Read side channel decode for both banks
	logic fc_rd_hit;
	logic fl_rd_hit;
	logic [2:0] fc_rd_chan;
	logic [2:0] fl_rd_chan;

	function automatic logic is_chan_reg(input logic [11:0] a, input logic [11:0] base, input int n);
		logic [11:0] top;
		top = base + 12'(n * 4);
		is_chan_reg = (a >= base) && (a < top) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [2:0] chan_of(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		chan_of = d[4:2];
	endfunction

	assign addr_ph = hsel & hready & htrans[1];
	assign rd_pend = addr_ph & ~hwrite;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Write lands at the edge that ends the data phase
	assign wr_uc_set = wr_pend_reg && (addr_reg == RXFP_UC_SET_OFS);
	assign wr_uc_clr = wr_pend_reg && (addr_reg == RXFP_UC_CLR_OFS);
	assign wr_maxlen = wr_pend_reg && (addr_reg == RXFP_MAXLEN_OFS);
	assign wr_skip = wr_pend_reg && (addr_reg == RXFP_SKIP_OFS);
	assign wr_lowth = wr_pend_reg && (addr_reg == RXFP_LOWTH_OFS);
	assign wr_flowen = wr_pend_reg && (addr_reg == RXFP_FLOWEN_OFS);

	// Read decoded in the address phase: a read right behind a write sees the old value
	assign fc_rd_hit = is_chan_reg(haddr, RXFP_FREE_OFS0, CHANNELS);
	assign fl_rd_hit = is_chan_reg(haddr, RXFP_FLOWTH_OFS0, CHANNELS);
	assign fc_rd_chan = chan_of(haddr, RXFP_FREE_OFS0);
	assign fl_rd_chan = chan_of(haddr, RXFP_FLOWTH_OFS0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
		end else begin
			wr_pend_reg <= addr_ph & hwrite;
		end
	end

	// Address held for the whole data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg <= 12'h000;
		end else if (addr_ph) begin
			addr_reg <= haddr;
		end
	end

	// Read mux; unmapped and reserved bits read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (haddr)
			RXFP_UC_SET_OFS, RXFP_UC_CLR_OFS: rdata_next[CHANNELS-1:0] = uc_reg;
			RXFP_MAXLEN_OFS: rdata_next[15:0] = max_frame_bytes_reg;
			RXFP_SKIP_OFS: rdata_next[15:0] = lead_skip_bytes_reg;
			RXFP_LOWTH_OFS: rdata_next[7:0] = low_priority_cutoff_reg;
			RXFP_FLOWEN_OFS: rdata_next[0] = flow_en_reg;
			default: begin
				if (fc_rd_hit) begin
					rdata_next[15:0] = free_count_reg[fc_rd_chan*16 +: 16];
				end else if (fl_rd_hit) begin
					rdata_next[7:0] = flow_level_reg[fl_rd_chan*8 +: 8];
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pend) begin
			hrdata <= rdata_next;
		end
	end

	always_comb begin
		uc_next = uc_reg;
		if (wr_uc_set) begin
			uc_next = uc_reg | hwdata[CHANNELS-1:0];
		end else if (wr_uc_clr) begin
			uc_next = uc_reg & ~hwdata[CHANNELS-1:0];
		end
	end

	// Zeros written to either register leave the bit alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			uc_reg <= RXFP_UC_RST;
		end else begin
			uc_reg <= uc_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			max_frame_bytes_reg <= RXFP_MAXLEN_RST;
		end else if (wr_maxlen) begin
			max_frame_bytes_reg <= hwdata[15:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lead_skip_bytes_reg <= RXFP_SKIP_RST;
		end else if (wr_skip) begin
			lead_skip_bytes_reg <= hwdata[15:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_priority_cutoff_reg <= RXFP_LOWTH_RST;
		end else if (wr_lowth) begin
			low_priority_cutoff_reg <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flow_en_reg <= 1'b0;
		end else if (wr_flowen) begin
			flow_en_reg <= hwdata[0];
		end
	end

	// Per-channel flow levels and free counts
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic [11:0] fl_ofs;
			logic [11:0] fc_ofs;
			logic fc_wr;
			logic fl_wr;
			logic [15:0] fc_add;
			logic [15:0] fc_next;
			assign fl_ofs = RXFP_FLOWTH_OFS0 + 12'(g * 4);
			assign fc_ofs = RXFP_FREE_OFS0 + 12'(g * 4);
			assign fc_wr = wr_pend_reg && addr_reg == fc_ofs;
			assign fl_wr = wr_pend_reg && addr_reg == fl_ofs;
			// Write adds, frame subtracts; both in one cycle combine
			assign fc_add = fc_wr ? hwdata[15:0] : 16'h0000;
			// Rolls over, no saturation; software must not overfill
			assign fc_next = free_count_reg[g*16 +: 16] + fc_add - {15'h0000, frame_buffers_used[g]};
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					flow_level_reg[g*8 +: 8] <= RXFP_FLOWTH_RST;
				end else if (fl_wr) begin
					flow_level_reg[g*8 +: 8] <= hwdata[7:0];
				end
			end
			// Free buffer count per channel
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					free_count_reg[g*16 +: 16] <= RXFP_FREE_RST;
				end else begin
					free_count_reg[g*16 +: 16] <= fc_next;
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sop_fields <= '0;
		end else if (sop_req) begin
			sop_fields.buffer_offset <= lead_skip_bytes_reg;
			sop_fields.lead_skip_bytes <= lead_skip_bytes_reg;
		end
	end

	// Fields hold after the pulse for a slow descriptor writer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sop_valid <= 1'b0;
		end else begin
			sop_valid <= sop_req;
		end
	end

	assign channel_unicast_accept = uc_reg;

	rxfp_classify u_classify (
		.hclk(hclk),
		.hresetn(hresetn),
		.frame_end(frame_end),
		.max_frame_bytes(max_frame_bytes_reg),
		.frame_class(frame_class),
		.frame_class_valid(frame_class_valid)
	);

	rxfp_threshold #(
		.CHANNELS(CHANNELS)
	) u_threshold (
		.hclk(hclk),
		.hresetn(hresetn),
		.low_cutoff(low_priority_cutoff_reg),
		.flow_levels(flow_level_reg),
		.free_counts(free_count_reg),
		.flow_enable(flow_en_reg),
		.low_filter(low_filter),
		.flow_issue(flow_issue)
	);
endmodule

//--- common/rxfp_pkg.sv
// Package for the receive frame policy register block
package rxfp_pkg;
	localparam int RXFP_CHANNELS = 8;
	// Register byte offsets
	localparam logic [11:0] RXFP_UC_SET_OFS = 12'h000;
	localparam logic [11:0] RXFP_UC_CLR_OFS = 12'h004;
	localparam logic [11:0] RXFP_MAXLEN_OFS = 12'h008;
	localparam logic [11:0] RXFP_SKIP_OFS = 12'h00C;
	localparam logic [11:0] RXFP_LOWTH_OFS = 12'h010;
	localparam logic [11:0] RXFP_FLOWEN_OFS = 12'h014;
	localparam logic [11:0] RXFP_FREE_OFS0 = 12'h020;
	localparam logic [11:0] RXFP_FLOWTH_OFS0 = 12'h040;
	// Reset values
	localparam logic [15:0] RXFP_MAXLEN_RST = 16'h05EE;
	localparam logic [15:0] RXFP_SKIP_RST = 16'h0000;
	localparam logic [7:0] RXFP_LOWTH_RST = 8'h00;
	localparam logic [7:0] RXFP_FLOWTH_RST = 8'h00;
	localparam logic [7:0] RXFP_UC_RST = 8'h00;
	localparam logic [15:0] RXFP_FREE_RST = 16'h0000;

	typedef struct packed {
		logic valid;
		logic [15:0] byte_count;
		logic crc_err;
		logic code_err;
		logic align_err;
	} rxfp_frame_end_t;

	typedef struct packed {
		logic long_frame;
		logic oversized;
		logic jabber;
	} rxfp_class_t;

	typedef struct packed {
		logic [15:0] buffer_offset;
		logic [15:0] lead_skip_bytes;
	} rxfp_sop_t;
endpackage

//--- rtl/rxfp_classify.sv
// Long, oversized and jabber classification of finished frames
`timescale 1ns/1ps
module rxfp_classify (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Frame end and limit
	input wire rxfp_pkg::rxfp_frame_end_t frame_end,
	input wire logic [15:0] max_frame_bytes,
	// Result
	output rxfp_pkg::rxfp_class_t frame_class,
	output logic frame_class_valid
);
	import rxfp_pkg::*;
	logic is_long;
	logic has_err;
	assign is_long = frame_end.byte_count > max_frame_bytes;
	assign has_err = frame_end.crc_err | frame_end.code_err | frame_end.align_err;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_class <= '0;
			frame_class_valid <= 1'b0;
		end else begin
			frame_class_valid <= frame_end.valid;
			if (frame_end.valid) begin
				frame_class.long_frame <= is_long;
				frame_class.oversized <= is_long & ~has_err;
				frame_class.jabber <= is_long & has_err;
			end
		end
	end
endmodule

//--- rtl/rxfp_threshold.sv
// Per-channel threshold compare against free buffer counts
`timescale 1ns/1ps
module rxfp_threshold #(
	parameter int CHANNELS = 8
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Levels and counts
	input wire logic [7:0] low_cutoff,
	input wire logic [CHANNELS*8-1:0] flow_levels,
	input wire logic [CHANNELS*16-1:0] free_counts,
	input wire logic flow_enable,
	// Decisions
	output logic [CHANNELS-1:0] low_filter,
	output logic [CHANNELS-1:0] flow_issue
);
	import rxfp_pkg::*;
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			logic [15:0] cnt;
			assign cnt = free_counts[g*16 +: 16];
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					low_filter[g] <= 1'b0;
					flow_issue[g] <= 1'b0;
				end else begin
					low_filter[g] <= cnt < {8'h00, low_cutoff};
					flow_issue[g] <= flow_enable & (cnt < {8'h00, flow_levels[g*8 +: 8]});
				end
			end
		end
	endgenerate
endmodule

//--- dv/rxfp_regs_props.sv
// Checker for register and frame result timing
`timescale 1ns/1ps
module rxfp_regs_props #(
	parameter int CHANNELS = 8
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Receive side
	input wire rxfp_pkg::rxfp_frame_end_t frame_end,
	input wire logic sop_req,
	input wire rxfp_pkg::rxfp_class_t frame_class,
	input wire logic frame_class_valid,
	input wire rxfp_pkg::rxfp_sop_t sop_fields,
	input wire logic sop_valid,
	input wire logic [CHANNELS-1:0] channel_unicast_accept
);
	import rxfp_pkg::*;
	logic wr_reg;
	logic rd_reg;
	logic [11:0] adr_reg;
	logic [15:0] skip_seen;
	logic [15:0] maxlen_seen;
	wire logic err_any = frame_end.crc_err | frame_end.code_err | frame_end.align_err;
	// Limit and skip rebuilt from bus writes, independent of the design's registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			skip_seen <= RXFP_SKIP_RST;
			maxlen_seen <= RXFP_MAXLEN_RST;
		end else if (wr_reg) begin
			if (adr_reg == RXFP_SKIP_OFS) begin
				skip_seen <= hwdata[15:0];
			end
			if (adr_reg == RXFP_MAXLEN_OFS) begin
				maxlen_seen <= hwdata[15:0];
			end
		end
	end
	// Data phase follows the taken address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			adr_reg <= 12'h000;
		end else begin
			wr_reg <= hsel && hready && htrans[1] && hwrite;
			rd_reg <= hsel && hready && htrans[1] && !hwrite;
			adr_reg <= haddr;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_class_follows: assert property (frame_end.valid |=> frame_class_valid)
		else $error("class valid missing");
	a_class_quiet: assert property (!frame_end.valid |=> !frame_class_valid)
		else $error("class valid without frame");
	a_oversize_clean: assert property (frame_end.valid |=>
		frame_class.oversized == (frame_class.long_frame && !$past(err_any))) else $error("oversized wrong");
	a_jabber_error: assert property (frame_end.valid |=>
		frame_class.jabber == (frame_class.long_frame && $past(err_any))) else $error("jabber wrong");
	a_long_limit: assert property (frame_end.valid |=>
		frame_class.long_frame == ($past(frame_end.byte_count) > $past(maxlen_seen))) else $error("long flag wrong");
	a_sop_copy: assert property (sop_req |=> sop_valid && sop_fields.buffer_offset == $past(skip_seen)
		&& sop_fields.lead_skip_bytes == $past(skip_seen)) else $error("first descriptor fields wrong");
	a_uc_clear: assert property (wr_reg && adr_reg == RXFP_UC_CLR_OFS |=>
		channel_unicast_accept == ($past(channel_unicast_accept) & ~$past(hwdata[CHANNELS-1:0])))
		else $error("unicast clear wrong");
	a_uc_set: assert property (wr_reg && adr_reg == RXFP_UC_SET_OFS |=>
		channel_unicast_accept == ($past(channel_unicast_accept) | $past(hwdata[CHANNELS-1:0])))
		else $error("unicast set wrong");
	a_uc_hold: assert property (!wr_reg |=> $stable(channel_unicast_accept))
		else $error("unicast enables moved");
	a_upper_zero: assert property (rd_reg |-> hrdata[31:16] == 16'h0000)
		else $error("reserved bits not zero");
	c_jabber: cover property (frame_class_valid && frame_class.jabber);
	c_oversize: cover property (frame_class_valid && frame_class.oversized);
	c_clear: cover property (wr_reg && adr_reg == RXFP_UC_CLR_OFS);
endmodule

bind rxfp_regs rxfp_regs_props #(.CHANNELS(CHANNELS)) u_props (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .frame_end, .sop_req, .frame_class, .frame_class_valid,
	.sop_fields, .sop_valid, .channel_unicast_accept);

//--- dv/rxfp_phy_model.sv
// Far-side frame source reporting finished frames
`timescale 1ns/1ps
module rxfp_phy_model (
	// Clock
	input wire logic hclk,
	// Frame end report
	output rxfp_pkg::rxfp_frame_end_t frame_end
);
	import rxfp_pkg::*;
	initial frame_end = '0;
	// Idle fields show the inverse so stale values cannot pass
	task automatic send(input logic [15:0] count, input logic [2:0] errs);
		@(posedge hclk);
		frame_end <= {1'b1, count, errs};
		@(posedge hclk);
		frame_end <= {1'b0, ~count, ~errs};
	endtask
endmodule

//--- dv/rx_frame_policy_regs_test.sv
// Self-checking bench for the receive frame policy registers
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; \
	$display("Error %s expected %h got %h", nm, ex, got); end end
module rx_frame_policy_regs_test;
	import rxfp_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic sop_req = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'b00;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [7:0] used = 8'h00;
	logic [7:0] accept;
	logic [7:0] low_filter;
	logic [7:0] flow_issue;
	logic class_valid;
	logic sop_valid;
	logic hresp;
	wire hready;
	rxfp_frame_end_t frame_end;
	rxfp_class_t frame_class;
	rxfp_sop_t sop_fields;
	int n_fail = 0;
	int samples_checked = 0;
	always #2.5 hclk = ~hclk;
	rxfp_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .frame_end(frame_end), .sop_req(sop_req),
		.frame_buffers_used(used), .frame_class(frame_class), .frame_class_valid(class_valid),
		.sop_fields(sop_fields), .sop_valid(sop_valid), .channel_unicast_accept(accept),
		.low_filter(low_filter), .flow_issue(flow_issue));
	rxfp_phy_model u_phy (.hclk(hclk), .frame_end(frame_end));
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		#1;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] ex, input string nm);
		xfer(1'b0, a, 32'h0000_0000);
		`CHK(nm, ex, rd)
	endtask
	task automatic settle();
		repeat (2) @(posedge hclk);
		#1;
	endtask
	task automatic t_reset();
		rchk(RXFP_MAXLEN_OFS, 32'h0000_05EE, "maxlen");
		rchk(RXFP_SKIP_OFS, 32'h0000_0000, "skip");
		rchk(12'h100, 32'h0000_0000, "unmapped");
		`CHK("resp", 1'b0, hresp)
		xfer(1'b1, RXFP_MAXLEN_OFS, 32'hFFFF_0064);
		rchk(RXFP_MAXLEN_OFS, 32'h0000_0064, "maxlen wr");
	endtask
	task automatic t_unicast();
		xfer(1'b1, RXFP_UC_SET_OFS, 32'hFFFF_FFFF);
		rchk(RXFP_UC_CLR_OFS, 32'h0000_00FF, "clear rd");
		xfer(1'b1, RXFP_UC_CLR_OFS, 32'h0000_00A5);
		xfer(1'b1, RXFP_UC_CLR_OFS, 32'h0000_0000);
		rchk(RXFP_UC_SET_OFS, 32'h0000_005A, "set rd");
		xfer(1'b1, RXFP_UC_SET_OFS, 32'h0000_0001);
		`CHK("accept", 8'h5B, accept)
	endtask
	task automatic t_class();
		logic [15:0] cnt[5] = '{16'h0064, 16'h0065, 16'h0065, 16'h0065, 16'hFFFF};
		logic [2:0] er[5] = '{3'b111, 3'b000, 3'b100, 3'b010, 3'b001};
		for (int i = 0; i < 5; i++) begin
			u_phy.send(cnt[i], er[i]);
			#1;
			`CHK("valid", 1'b1, class_valid)
			`CHK("long", i > 0, frame_class.long_frame)
			`CHK("oversized", i == 1, frame_class.oversized)
			`CHK("jabber", i > 1, frame_class.jabber)
		end
	endtask
	task automatic t_sop();
		logic [15:0] sk[2] = '{16'h000F, 16'h0000};
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, RXFP_SKIP_OFS, {16'hFFFF, sk[i]});
			@(posedge hclk);
			sop_req <= 1'b1;
			@(posedge hclk);
			sop_req <= 1'b0;
			#1;
			`CHK("sop valid", 1'b1, sop_valid)
			`CHK("sop fields", {sk[i], sk[i]}, sop_fields)
		end
	endtask
	task automatic t_thresh();
		xfer(1'b1, RXFP_FREE_OFS0, 32'h0000_0005);
		xfer(1'b1, RXFP_LOWTH_OFS, 32'h0000_0005);
		settle();
		`CHK("low filter", 8'hFE, low_filter)
		xfer(1'b1, RXFP_LOWTH_OFS, 32'h0000_0000);
		xfer(1'b1, RXFP_FLOWTH_OFS0, 32'h0000_0005);
		xfer(1'b1, RXFP_FLOWTH_OFS0 + 12'h00C, 32'h0000_0006);
		settle();
		`CHK("low zero", 8'h00, low_filter)
		`CHK("flow off", 8'h00, flow_issue)
		xfer(1'b1, RXFP_FLOWEN_OFS, 32'h0000_0001);
		settle();
		`CHK("flow on", 8'h08, flow_issue)
		@(posedge hclk);
		used <= 8'h01;
		@(posedge hclk);
		used <= 8'h00;
		settle();
		`CHK("flow used", 8'h09, flow_issue)
		rchk(RXFP_FREE_OFS0, 32'h0000_0004, "free count");
	endtask
	task automatic final_report();
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_unicast();
		t_class();
		t_sop();
		t_thresh();
		final_report();
	end
	initial begin
		#50000;
		n_fail++;
		final_report();
	end
endmodule
